/* File: verilog/sbp_pkg.sv */
package sbp_pkg;
  localparam logic [4:0] SBP_ADDR_HI = 5'h12;
  localparam logic [7:0] SBP_PTR_RESET = 8'h00;
  localparam logic [2:0] SBP_BIT_LAST = 3'h7;
  localparam logic [2:0] SBP_BIT_FIRST = 3'h0;
  localparam logic [2:0] SBP_BIT_STEP = 3'h1;
  localparam logic [7:0] SBP_PTR_STEP = 8'h01;

  typedef enum {
    SBP_IDLE,
    SBP_ADDR,
    SBP_ADDR_ACK,
    SBP_PTR,
    SBP_PTR_ACK,
    SBP_WDATA,
    SBP_WDATA_ACK,
    SBP_RDATA,
    SBP_RDATA_ACK
  } sbp_state_t;

  // register-space access toward the bay control logic
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbp_reg_req_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic [1:0] sel_wait;
    logic [1:0] slave_lo;
    logic sel_taken;
    sbp_state_t state;
    logic [2:0] bit_cnt;
    logic byte_full;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sda_low;
    logic alert_low;
    sbp_reg_req_t req;
  } sbp_state_reg_t;
endpackage : sbp_pkg

/* File: verilog/sbp_slave.sv */
// Functional notes
// - answer only address 10010 plus the two sampled select bits.
// - direction bit 0 means write, 1 means read.
// - first write byte after address loads the pointer.
// - pointer clears to zero on reset.
// - further write bytes store at pointer, pointer then increments.
// - reads send from pointer while master acknowledges.
// - on read not-acknowledge release data and wait for start.
// - pointer increments as each read byte is loaded for sending.
// - writes to unimplemented locations are dropped by the register side.
// - alert pulled low while an interrupt event is pending.
// - alert stays low until status or enable bit clears.
// - ignore alert response address and general call.
// - start is sda fall with scl high, stop is sda rise.
// - acknowledge matching address and each written byte.
// - pointer wraps from highest value to zero.
// - select pins sampled right after reset.
module sbp_slave
  import sbp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps and alert
  input wire logic [1:0] address_select_pins,
  input wire logic irq_pending,
  output logic alert_request_n,
  output logic alert_oe_n,
  // register space
  output sbp_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);

  sbp_state_reg_t st_reg;
  sbp_state_reg_t st_next;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // shared by write, first read and burst read; wraps FF to 00
  function automatic logic [7:0] sbp_ptr_inc(input logic [7:0] p);
    return p + SBP_PTR_STEP;
  endfunction : sbp_ptr_inc

  assign scl = st_reg.scl_sync[1];
  assign sda = st_reg.sda_sync[1];
  assign scl_rise = scl && !st_reg.scl_prev;
  assign scl_fall = !scl && st_reg.scl_prev;
  assign start_cond = scl && st_reg.scl_prev && st_reg.sda_prev && !sda;
  assign stop_cond = scl && st_reg.scl_prev && !st_reg.sda_prev && sda;

  always_comb begin
    st_next = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[0], scl_in};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_in};
    st_next.sel_meta = address_select_pins;
    st_next.sel_sync = st_reg.sel_meta;
    st_next.sel_wait = {st_reg.sel_wait[0], 1'b1};
    st_next.scl_prev = scl;
    st_next.sda_prev = sda;
    st_next.req.wr_en = 1'b0;
    st_next.req.rd_en = 1'b0;
    // alert follows the pending level from the event logic
    st_next.alert_low = irq_pending;
    // straps taken once, after both sync stages have filled
    if (!st_reg.sel_taken && st_reg.sel_wait[1]) begin
      st_next.sel_taken = 1'b1;
      st_next.slave_lo = st_reg.sel_sync;
    end
    if (start_cond) begin
      st_next.state = SBP_ADDR;
      st_next.bit_cnt = SBP_BIT_FIRST;
      st_next.byte_full = 1'b0;
      st_next.sda_low = 1'b0;
    end else if (stop_cond) begin
      st_next.state = SBP_IDLE;
      st_next.sda_low = 1'b0;
    end else begin
      case (st_reg.state)
        SBP_IDLE: begin
          st_next.sda_low = 1'b0;
        end
        SBP_ADDR, SBP_PTR, SBP_WDATA: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], sda};
            st_next.bit_cnt = st_reg.bit_cnt + SBP_BIT_STEP;
            // counter is zero both before and after a byte, so flag it
            st_next.byte_full = (st_reg.bit_cnt == SBP_BIT_LAST);
          end
          if (scl_fall && st_reg.byte_full) begin
            st_next.byte_full = 1'b0;
            case (st_reg.state)
              SBP_ADDR: begin
                // match only own address; others ignored
                if (st_reg.shift[7:1] == {SBP_ADDR_HI, st_reg.slave_lo}) begin
                  st_next.sda_low = 1'b1;
                  st_next.state = SBP_ADDR_ACK;
                end else begin
                  st_next.state = SBP_IDLE;
                end
              end
              SBP_PTR: begin
                st_next.ptr = st_reg.shift;
                st_next.sda_low = 1'b1;
                st_next.state = SBP_PTR_ACK;
              end
              default: begin
                st_next.req.wr_en = 1'b1;
                st_next.req.addr = st_reg.ptr;
                st_next.req.wdata = st_reg.shift;
                st_next.ptr = sbp_ptr_inc(st_reg.ptr);
                st_next.sda_low = 1'b1;
                st_next.state = SBP_WDATA_ACK;
              end
            endcase
          end
        end
        SBP_ADDR_ACK, SBP_PTR_ACK, SBP_WDATA_ACK: begin
          if (scl_fall) begin
            st_next.sda_low = 1'b0;
            st_next.bit_cnt = SBP_BIT_FIRST;
            if (st_reg.state == SBP_ADDR_ACK) begin
              if (st_reg.shift[0]) begin
                st_next.shift = reg_rdata;
                st_next.req.rd_en = 1'b1;
                st_next.req.addr = st_reg.ptr;
                st_next.ptr = sbp_ptr_inc(st_reg.ptr);
                st_next.sda_low = !reg_rdata[7];
                st_next.state = SBP_RDATA;
              end else begin
                st_next.state = SBP_PTR;
              end
            end else begin
              st_next.state = SBP_WDATA;
            end
          end
        end
        SBP_RDATA: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == SBP_BIT_LAST) begin
              st_next.sda_low = 1'b0;
              // only the master's ack sets the counter back to last
              st_next.bit_cnt = SBP_BIT_FIRST;
              st_next.state = SBP_RDATA_ACK;
            end else begin
              st_next.bit_cnt = st_reg.bit_cnt + SBP_BIT_STEP;
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sda_low = !st_reg.shift[6];
            end
          end
        end
        SBP_RDATA_ACK: begin
          if (scl_rise) begin
            if (sda) begin
              st_next.state = SBP_IDLE;
            end else begin
              st_next.bit_cnt = SBP_BIT_LAST;
            end
          end
          if (scl_fall && st_reg.bit_cnt == SBP_BIT_LAST) begin
            st_next.bit_cnt = SBP_BIT_FIRST;
            st_next.shift = reg_rdata;
            st_next.req.rd_en = 1'b1;
            st_next.req.addr = st_reg.ptr;
            st_next.ptr = sbp_ptr_inc(st_reg.ptr);
            st_next.sda_low = !reg_rdata[7];
            st_next.state = SBP_RDATA;
          end
        end
        default: begin
          st_next.state = SBP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.ptr <= SBP_PTR_RESET;
      st_reg.state <= SBP_IDLE;
      st_reg.scl_sync <= 2'h3;
      st_reg.sda_sync <= 2'h3;
      st_reg.scl_prev <= 1'b1;
      st_reg.sda_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = !st_reg.sda_low;
  assign alert_request_n = !st_reg.alert_low;
  assign alert_oe_n = !st_reg.alert_low;
  assign reg_req = st_reg.req;

  // ack driven only in an acknowledge state
  ack_drive_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.sda_low && st_reg.state != SBP_RDATA) |->
    (st_reg.state inside {SBP_ADDR_ACK, SBP_PTR_ACK, SBP_WDATA_ACK}))
    else $error("data line low outside acknowledge");
  // alert follows pending level with one cycle lag
  alert_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    irq_pending |=> !alert_request_n)
    else $error("alert not asserted");
  // write strobe carries the pointer before its increment
  wr_ptr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reg_req.wr_en |-> st_reg.ptr == sbp_ptr_inc(reg_req.addr))
    else $error("pointer not advanced after write");
  nack_idle_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.state == SBP_RDATA_ACK && scl_rise && sda && !stop_cond &&
     !start_cond) |=> st_reg.state == SBP_IDLE && sda_oe_n)
    else $error("read not ended on nack");
  start_addr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    start_cond |=> st_reg.state == SBP_ADDR &&
    st_reg.bit_cnt == SBP_BIT_FIRST && !st_reg.byte_full)
    else $error("start not restarting");
  // foreign address leaves line and pointer alone
  nomatch_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.state == SBP_ADDR && st_reg.byte_full && scl_fall &&
     !start_cond && !stop_cond &&
     st_reg.shift[7:1] != {SBP_ADDR_HI, st_reg.slave_lo}) |=>
    (st_reg.state == SBP_IDLE && sda_oe_n && $stable(st_reg.ptr)))
    else $error("foreign address not ignored");
  rd_ptr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reg_req.rd_en |-> st_reg.ptr == sbp_ptr_inc(reg_req.addr))
    else $error("pointer not advanced after read");
  ptr_load_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.state == SBP_PTR && st_next.state == SBP_PTR_ACK) |=>
    st_reg.ptr == $past(st_reg.shift))
    else $error("pointer not loaded");
  idle_release_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_reg.state == SBP_IDLE |-> sda_oe_n)
    else $error("data line driven while idle");
  idle_ptr_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.state == SBP_IDLE && !start_cond) |=> $stable(st_reg.ptr))
    else $error("pointer moved while idle");
  ack_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_reg.state inside {SBP_ADDR_ACK, SBP_PTR_ACK, SBP_WDATA_ACK} |->
    !sda_oe_n)
    else $error("acknowledge not driven");
  // line free for the master's ack bit
  rack_release_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_reg.state == SBP_RDATA_ACK |-> sda_oe_n)
    else $error("line driven in master ack");
  // alert released once cause is gone
  alert_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !irq_pending |=> alert_request_n && alert_oe_n)
    else $error("alert held without cause");
  strap_take_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!st_reg.sel_taken && st_reg.sel_wait[1]) |=>
    st_reg.sel_taken && st_reg.slave_lo == $past(st_reg.sel_sync))
    else $error("straps not taken");
  strap_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_reg.sel_taken |=> $stable(st_reg.slave_lo))
    else $error("straps changed after sampling");
  // stored byte is the byte received
  wr_data_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reg_req.wr_en |-> reg_req.wdata == $past(st_reg.shift))
    else $error("write data differs from received byte");
  // one register access at a time
  strobe_excl_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !(reg_req.wr_en && reg_req.rd_en))
    else $error("read and write strobes together");
  read_launch_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.state == SBP_ADDR_ACK && scl_fall && st_reg.shift[0] &&
     !start_cond && !stop_cond) |=>
    reg_req.rd_en && st_reg.state == SBP_RDATA)
    else $error("read byte not launched");
endmodule : sbp_slave

/* File: test/sbp_host.sv */
module sbp_host (
  // serial pins
  output logic scl,
  output logic sda_drv,
  input wire logic sda_bus
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock idles high between frames, line released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // start edge
  // line let go mid-low so a slave ack is gone before the clock rises
  task automatic start_c;
    #8 sda_drv = 1'b1;
    #24 scl = 1'b1;
    #16 sda_drv = 1'b0;
    #16 scl = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #8 sda_drv = 1'b0;
    #24 scl = 1'b1;
    #16 sda_drv = 1'b1;
    #16;
  endtask : stop_c

  // data moves mid-low, sampled mid-high
  task automatic bit_c(input logic b, output logic r);
    #8 sda_drv = b;
    #24 scl = 1'b1;
    #16 r = sda_bus;
    #16 scl = 1'b0;
  endtask : bit_c

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);
    bit_c(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, r);
      d[i] = r;
    end
    bit_c(!more, r);
  endtask : rd_byte
endmodule : sbp_host

/* File: test/sbp_slave_tb.sv */
module sbp_slave_tb
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ADR = {SBP_ADDR_HI, 2'h2, 1'b0};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] sel = 2'h2;
  logic irq = 1'b0;
  logic scl, sda_drv, sda_oe_n, sda_out, alert_n, alert_oe_n, k;
  sbp_reg_req_t req;
  logic [7:0] mem [256];
  logic [7:0] exp_ptr = 8'h00;
  logic [23:0] rows [3] = '{24'h089A55, 24'hFF3CC3, 24'h7E00FF};
  logic [7:0] bad [3] = '{8'h92, 8'h00, 8'h19};
  int fail_count = 0;
  int tests_run = 0;
  // pull-up: line low only when someone drives it
  wire logic sda_bus = sda_drv & (sda_oe_n | sda_out);

  sbp_slave i_sbp_slave (.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pins(sel), .irq_pending(irq),
    .alert_request_n(alert_n), .alert_oe_n(alert_oe_n),
    .reg_req(req), .reg_rdata(mem[exp_ptr]));
  sbp_host i_sbp_host (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));

  initial forever #2.5 ref_clk = ~ref_clk;

  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // register side; every access must hit the tracked pointer
  always @(posedge ref_clk) begin
    if (req.wr_en === 1'b1 || req.rd_en === 1'b1) begin
      chk8(req.addr, exp_ptr);
      if (req.wr_en === 1'b1) mem[req.addr] <= req.wdata;
      exp_ptr <= exp_ptr + 8'h01;
    end
  end

  task automatic wr_seq(input logic [7:0] p, input logic [15:0] d,
                        input int n);
    i_sbp_host.start_c();
    i_sbp_host.wr_byte(ADR, k);
    chk1(k, 1'b0);
    i_sbp_host.wr_byte(p, k);
    chk1(k, 1'b0);
    exp_ptr = p;
    for (int j = 0; j < n; j++) begin
      i_sbp_host.wr_byte(d[15-8*j -: 8], k);
      chk1(k, 1'b0);
    end
  endtask : wr_seq

  task automatic rd_seq(input logic [7:0] e0, input logic [7:0] e1,
                        input int n);
    logic [7:0] d;
    i_sbp_host.start_c();
    i_sbp_host.wr_byte(ADR | 8'h01, k);
    chk1(k, 1'b0);
    i_sbp_host.rd_byte(n > 1, d);
    chk8(d, e0);
    if (n > 1) begin
      i_sbp_host.rd_byte(1'b0, d);
      chk8(d, e1);
    end
    i_sbp_host.stop_c();
    chk1(sda_oe_n, 1'b1);
  endtask : rd_seq

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sel <= 2'h1;
    chk1(alert_n, 1'b1);
    repeat (8) @(posedge ref_clk);
    rd_seq(8'hA5, 8'h00, 1);
    foreach (bad[i]) begin
      i_sbp_host.start_c();
      i_sbp_host.wr_byte(bad[i], k);
      chk1(k, 1'b1);
      i_sbp_host.wr_byte(8'h40, k);
      chk1(k, 1'b1);
      i_sbp_host.stop_c();
    end
    rd_seq(8'hA4, 8'hA7, 2);
    foreach (rows[i]) begin
      wr_seq(rows[i][23:16], rows[i][15:0], 2);
      i_sbp_host.stop_c();
      wr_seq(rows[i][23:16], 16'h0000, 0);
      rd_seq(rows[i][15:8], rows[i][7:0], 2);
    end
    wr_seq(8'h33, 16'h0000, 0);
    i_sbp_host.stop_c();
    @(posedge ref_clk);
    sel <= 2'h2;
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    exp_ptr = 8'h00;
    repeat (8) @(posedge ref_clk);
    rd_seq(8'hC3, 8'h00, 1);
    wr_seq(8'h7F, 16'h0000, 0);
    i_sbp_host.stop_c();
    rd_seq(8'hFF, 8'h00, 1);
    @(posedge ref_clk);
    irq <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk1(alert_n, 1'b0);
    chk1(alert_oe_n, 1'b0);
    rd_seq(8'h25, 8'h00, 1);
    chk1(alert_n, 1'b0);
    @(posedge ref_clk);
    irq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk1(alert_n, 1'b1);
    chk1(alert_oe_n, 1'b1);
    end_sim();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
endmodule : sbp_slave_tb
